/* hw/ps_pkg.sv */
// Constants and field layout of the proportional stride configuration block
package ps_pkg;
  localparam int PS_ADDR_W = 12;
  localparam logic [11:0] PS_OFF_CFG = 12'h500;
  localparam logic [11:0] PS_OFF_SEL = 12'h010;
  localparam int PS_EN_BIT = 31;
  localparam int PS_STRIDE_W = 16;
  localparam int PS_STRIDE_IMPL_W = 12;
  localparam logic [15:0] PS_STRIDE_MASK = 16'h0fff;
  localparam logic [5:0] PS_STRIDE_WIDTH_FIELD = 6'h0c;
  localparam int PS_SEL_PID_W = 16;
  localparam int PS_SEL_INT_BIT = 16;
  localparam int PS_SEL_INST_LSB = 24;
  localparam int PS_SEL_INST_MSB = 27;
  localparam int PS_PARTITION_W = 3;
  localparam int PS_INST_W = 1;
  localparam int PS_NUM_INST = 2;
  localparam int PS_NUM_SPACE = 4;
  localparam int PS_ENTRIES = 64;
  localparam int PS_ENT_W = 17;
  localparam int PS_NUM_REQ = 32;
  localparam int PS_REQ_IDX_W = 5;
  localparam int PS_PASS_W = 18;
  localparam logic PS_BW_PART_PRESENT = 1'b1;
  localparam logic PS_STRIDE_CTRL_PRESENT = 1'b1;
  localparam logic PS_INST_SEL_PRESENT = 1'b1;
  localparam logic PS_HAS_NRW = 1'b1;
  localparam logic PS_HAS_RME = 1'b1;
  typedef enum logic [1:0] {
    PS_SPACE_S = 2'h0,
    PS_SPACE_NS = 2'h1,
    PS_SPACE_RT = 2'h2,
    PS_SPACE_RL = 2'h3
  } ps_space_t;
endpackage : ps_pkg

/* hw/ps_stride_arb.sv */
// Proportional stride regulator sharing bandwidth among competing partitions
`timescale 1ns/1ns
module ps_stride_arb
  import ps_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [PS_NUM_REQ-1:0] req,
  input wire logic [PS_NUM_REQ-1:0] en,
  input wire logic [PS_NUM_REQ-1:0][PS_STRIDE_W-1:0] stride,
  output logic [PS_NUM_REQ-1:0] grant,
  output logic grant_valid
);
  logic [PS_NUM_REQ-1:0][PS_PASS_W-1:0] pass_q, pass_d;
  logic [PS_NUM_REQ-1:0] grant_q, grant_d;
  logic valid_q, valid_d;
  logic unreg_hit, best_hit;
  logic [PS_REQ_IDX_W-1:0] unreg_idx, best_idx;
  logic [PS_PASS_W-1:0] best_pass;

  always_comb begin
    unreg_hit = 1'b0;
    unreg_idx = '0;
    best_hit = 1'b0;
    best_idx = '0;
    best_pass = '1;
    for (int i = 0; i < PS_NUM_REQ; i++) begin
      if (req[i] && !en[i] && !unreg_hit) begin
        unreg_hit = 1'b1;
        unreg_idx = PS_REQ_IDX_W'(i);
      end
      if (req[i] && en[i] && (!best_hit || pass_q[i] < best_pass)) begin
        best_hit = 1'b1;
        best_idx = PS_REQ_IDX_W'(i);
        best_pass = pass_q[i];
      end
    end
    grant_d = '0;
    valid_d = unreg_hit || best_hit;
    pass_d = pass_q;
    if (unreg_hit) begin
      grant_d[unreg_idx] = 1'b1;
    end else if (best_hit) begin
      grant_d[best_idx] = 1'b1;
      for (int i = 0; i < PS_NUM_REQ; i++) begin
        pass_d[i] = (pass_q[i] > best_pass) ? pass_q[i] - best_pass : '0;
      end
      pass_d[best_idx] = PS_PASS_W'(stride[best_idx]) + PS_PASS_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pass_q <= '0;
      grant_q <= '0;
      valid_q <= 1'b0;
    end else begin
      pass_q <= pass_d;
      grant_q <= grant_d;
      valid_q <= valid_d;
    end
  end

  assign grant = grant_q;
  assign grant_valid = valid_q;

  grant_onehot_a: assert property (@(posedge mclk) disable iff (rst)
    $onehot0(grant_q) && (valid_q == (grant_q != '0)))
    else $error("grant not one-hot or valid mismatch");
  grant_req_a: assert property (@(posedge mclk) disable iff (rst)
    (req != '0) |=> ((grant_q & $past(req)) == grant_q) && valid_q)
    else $error("grant without request");
  unreg_first_a: assert property (@(posedge mclk) disable iff (rst)
    ((req & ~en) != '0) |=> ((grant_q & $past(req & ~en)) != '0))
    else $error("unregulated requester not served first");
endmodule : ps_stride_arb

/* hw/ps_stride_cfg.sv */
// Per-partition proportional stride configuration registers and regulator
//
// How it works
// - One stride setting per partition, reached via current partition selection.
// - Bit 31 enables stride regulation for the selected partition.
// - Bits 15:0 hold stride minus one, the partition's normalized cost.
// - Larger stride means higher cost and smaller bandwidth share.
// - Strides are weighed against all partitions competing at that moment.
// - Implemented stride width is reported; only those low bits are stored.
// - Register exists only with feature, bandwidth and stride support; else reads zero.
// - Four separate instances, one per security space, each using its own selection.
// - Each instance reachable from its own space's feature page.
// - With instance selection, access targets chosen instance plus partition.
// - Without instance selection, access is indexed by partition alone.
// - With narrowing, internal IDs are used and the internal flag must be one.
// - Without narrowing, request IDs are used and the internal flag stays zero.
// - Register sits at offset 0x0500 in each frame, read and write.
// - Root and Realm instances exist only with realm management.
// - Internal flag bit 16 reads zero, ignores writes without narrowing.
`timescale 1ns/1ns
module ps_stride_cfg
  import ps_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [1:0] cfg_space,
  input wire logic [PS_ADDR_W-1:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic [PS_NUM_INST-1:0][PS_NUM_REQ-1:0] bw_req,
  output logic [PS_NUM_INST-1:0][PS_NUM_REQ-1:0] bw_grant,
  output logic [PS_NUM_INST-1:0] bw_grant_valid,
  output logic [5:0] stride_width
);
  logic [PS_ENT_W-1:0] ent_q [PS_ENTRIES];
  logic [PS_ENT_W-1:0] ent_d [PS_ENTRIES];
  logic [PS_ENTRIES*PS_ENT_W-1:0] ent_flat;
  logic [PS_SEL_PID_W-1:0] sel_pid_q [PS_NUM_SPACE];
  logic [PS_SEL_PID_W-1:0] sel_pid_d [PS_NUM_SPACE];
  logic [3:0] sel_inst_q [PS_NUM_SPACE];
  logic [3:0] sel_inst_d [PS_NUM_SPACE];
  logic sel_int_q [PS_NUM_SPACE];
  logic sel_int_d [PS_NUM_SPACE];
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [5:0] width_q, width_d;
  logic space_ok, present, pid_ok, inst_ok, id_ok, cfg_ok;
  logic hit_cfg, hit_sel, wr_hit, sel_wr;
  logic [PS_SEL_PID_W-1:0] cur_pid;
  logic [3:0] cur_inst;
  logic cur_int;
  logic [PS_INST_W-1:0] inst_eff;
  logic [5:0] idx;
  logic [PS_ENT_W-1:0] wr_val;

  // Access decode against the selection of the accessing space
  always_comb begin
    cur_pid = sel_pid_q[cfg_space];
    cur_inst = sel_inst_q[cfg_space];
    cur_int = sel_int_q[cfg_space];
    space_ok = PS_HAS_RME || (cfg_space == PS_SPACE_S) || (cfg_space == PS_SPACE_NS);
    present = PS_BW_PART_PRESENT && PS_STRIDE_CTRL_PRESENT;
    pid_ok = (cur_pid[PS_SEL_PID_W-1:PS_PARTITION_W] == '0);
    inst_ok = !PS_INST_SEL_PRESENT || (cur_inst[3:PS_INST_W] == '0);
    inst_eff = PS_INST_SEL_PRESENT ? cur_inst[PS_INST_W-1:0] : '0;
    id_ok = PS_HAS_NRW ? cur_int : !cur_int;
    cfg_ok = present && space_ok && pid_ok && inst_ok && id_ok;
    idx = {cfg_space, inst_eff, cur_pid[PS_PARTITION_W-1:0]};
    hit_cfg = cfg_req && (cfg_addr == PS_OFF_CFG);
    hit_sel = cfg_req && (cfg_addr == PS_OFF_SEL) && space_ok;
    wr_hit = hit_cfg && cfg_write && cfg_ok;
    sel_wr = hit_sel && cfg_write;
    // keep enable and implemented stride bits
    wr_val = {cfg_wdata[PS_EN_BIT], cfg_wdata[PS_STRIDE_W-1:0] & PS_STRIDE_MASK};
  end

  // Selection register per space
  generate
    for (genvar s = 0; s < PS_NUM_SPACE; s++) begin : g_sel
      always_comb begin
        sel_pid_d[s] = sel_pid_q[s];
        sel_inst_d[s] = sel_inst_q[s];
        sel_int_d[s] = sel_int_q[s];
        if (sel_wr && (cfg_space == 2'(s))) begin
          sel_pid_d[s] = cfg_wdata[PS_SEL_PID_W-1:0];
          sel_inst_d[s] = PS_INST_SEL_PRESENT ? cfg_wdata[PS_SEL_INST_MSB:PS_SEL_INST_LSB] : 4'h0;
          sel_int_d[s] = PS_HAS_NRW && cfg_wdata[PS_SEL_INT_BIT];
        end
      end
      always_ff @(posedge mclk) begin
        if (rst) begin
          sel_pid_q[s] <= '0;
          sel_inst_q[s] <= 4'h0;
          sel_int_q[s] <= 1'b0;
        end else begin
          sel_pid_q[s] <= sel_pid_d[s];
          sel_inst_q[s] <= sel_inst_d[s];
          sel_int_q[s] <= sel_int_d[s];
        end
      end
    end
  endgenerate

  // Stride settings, one entry per space, instance and partition
  generate
    for (genvar e = 0; e < PS_ENTRIES; e++) begin : g_ent
      always_comb begin
        ent_d[e] = ent_q[e];
        if (wr_hit && (idx == 6'(e))) begin
          ent_d[e] = wr_val;
        end
      end
      always_ff @(posedge mclk) begin
        if (rst) begin
          ent_q[e] <= '0;
        end else begin
          ent_q[e] <= ent_d[e];
        end
      end
      assign ent_flat[e*PS_ENT_W +: PS_ENT_W] = ent_q[e];
    end
  endgenerate

  // Read answer one cycle after the request
  always_comb begin
    ack_d = cfg_req;
    rdata_d = 32'h0;
    width_d = PS_STRIDE_WIDTH_FIELD;
    if (hit_cfg && !cfg_write && cfg_ok) begin
      rdata_d = {ent_q[idx][PS_STRIDE_W], 15'h0, ent_q[idx][PS_STRIDE_W-1:0]};
    end else if (hit_sel && !cfg_write) begin
      rdata_d = {4'h0, cur_inst, 7'h0, cur_int, cur_pid};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      width_q <= 6'h0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      width_q <= width_d;
    end
  end

  assign cfg_ack = ack_q;
  assign cfg_rdata = rdata_q;
  assign stride_width = width_q;

  // One regulator per resource instance over all spaces and partitions
  generate
    for (genvar r = 0; r < PS_NUM_INST; r++) begin : g_arb
      logic [PS_NUM_REQ-1:0] en_v;
      logic [PS_NUM_REQ-1:0][PS_STRIDE_W-1:0] stride_v;
      for (genvar j = 0; j < PS_NUM_REQ; j++) begin : g_req
        localparam int E = (j / 8) * 16 + r * 8 + (j % 8);
        assign en_v[j] = ent_q[E][PS_STRIDE_W];
        assign stride_v[j] = ent_q[E][PS_STRIDE_W-1:0];
      end
      ps_stride_arb u_arb (
        .mclk(mclk),
        .rst(rst),
        .req(bw_req[r]),
        .en(en_v),
        .stride(stride_v),
        .grant(bw_grant[r]),
        .grant_valid(bw_grant_valid[r])
      );
    end
  endgenerate

  ack_timing_a: assert property (@(posedge mclk) disable iff (rst)
    cfg_req |=> cfg_ack)
    else $error("no answer one cycle after request");
  rsvd_bits_a: assert property (@(posedge mclk) disable iff (rst)
    hit_cfg |=> (cfg_rdata[30:16] == 15'h0) && ((cfg_rdata[15:0] & ~PS_STRIDE_MASK) == 16'h0))
    else $error("reserved or unimplemented bits read nonzero");
  write_store_a: assert property (@(posedge mclk) disable iff (rst)
    wr_hit |=> ent_flat[$past(idx)*PS_ENT_W +: PS_ENT_W] == $past(wr_val))
    else $error("write not stored in selected entry");
  readback_a: assert property (@(posedge mclk) disable iff (rst)
    wr_hit ##1 (hit_cfg && !cfg_write && cfg_ok && idx == $past(idx)) |=>
      cfg_rdata == {$past(wr_val[PS_STRIDE_W], 2), 15'h0, $past(wr_val[PS_STRIDE_W-1:0], 2)})
    else $error("readback differs from written value");
  root_block_a: assert property (@(posedge mclk) disable iff (rst)
    (!PS_HAS_RME && cfg_req && cfg_space[1]) |=> cfg_rdata == 32'h0)
    else $error("root or realm access without realm support");
  int_raz_a: assert property (@(posedge mclk) disable iff (rst)
    (!PS_HAS_NRW && hit_sel && !cfg_write) |=> !cfg_rdata[PS_SEL_INT_BIT])
    else $error("internal flag reads one without narrowing");
  reset_clear_a: assert property (@(posedge mclk)
    $past(rst) |-> ent_flat == '0)
    else $error("settings not cleared by reset");
  no_stray_write_a: assert property (@(posedge mclk) disable iff (rst)
    !wr_hit |=> $stable(ent_flat))
    else $error("setting changed without a valid write");
  id_guard_a: assert property (@(posedge mclk) disable iff (rst)
    (PS_HAS_NRW && hit_cfg && cfg_write && !cur_int) |=> $stable(ent_flat))
    else $error("write taken with internal flag clear");
endmodule : ps_stride_cfg

/* verif/ps_stride_cfg_test.sv */
// Self-checking testbench for the proportional stride configuration block
`timescale 1ns/1ns
module ps_stride_cfg_test;
  import ps_pkg::*;
  logic mclk, rst, cfg_req, cfg_write, cfg_ack;
  logic [1:0] cfg_space;
  logic [PS_ADDR_W-1:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  logic [PS_NUM_INST-1:0][PS_NUM_REQ-1:0] bw_req, bw_grant;
  logic [PS_NUM_INST-1:0] bw_grant_valid;
  logic [5:0] stride_width;
  int miscompares, tests_run, cycles, n_a, n_b, k;

  ps_stride_cfg dut_u (.mclk(mclk), .rst(rst), .cfg_req(cfg_req), .cfg_write(cfg_write),
    .cfg_space(cfg_space), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .bw_req(bw_req), .bw_grant(bw_grant), .bw_grant_valid(bw_grant_valid),
    .stride_width(stride_width));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One access: request held one cycle, answer sampled the cycle after
  task acc(input logic wr, input logic [1:0] sp, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk);
    cfg_req <= 1'b1;
    cfg_write <= wr;
    cfg_space <= sp;
    cfg_addr <= a;
    cfg_wdata <= wd;
    @(posedge mclk);
    cfg_req <= 1'b0;
    #1;
    chk({31'h0, cfg_ack}, 32'h1, "answer strobe");
    rd = cfg_rdata;
  endtask : acc

  // Setting written then read in back-to-back cycles
  task wr_rd(input logic [1:0] sp, input logic [31:0] wd);
    @(posedge mclk);
    cfg_req <= 1'b1;
    cfg_write <= 1'b1;
    cfg_space <= sp;
    cfg_addr <= PS_OFF_CFG;
    cfg_wdata <= wd;
    @(posedge mclk);
    cfg_write <= 1'b0;
    #1;
    chk({31'h0, cfg_ack}, 32'h1, "write answer");
    @(posedge mclk);
    cfg_req <= 1'b0;
    #1;
    chk({31'h0, cfg_ack}, 32'h1, "read answer");
    rd = cfg_rdata;
  endtask : wr_rd

  function automatic logic [31:0] selw(input logic [1:0] r, input logic [15:0] p, input logic i);
    return {4'h0, 2'h0, r, 7'h0, i, p};
  endfunction : selw

  function automatic logic [31:0] pat(input int n, input logic full);
    return {n[0], full ? 15'h7fff : 15'h0, full ? 4'hf : 4'h0, 4'ha, n[3:0], 4'(15 - n)};
  endfunction : pat

  task gather;
    n_a = 0;
    n_b = 0;
    repeat (16) begin
      @(posedge mclk);
      #1;
      if (bw_grant[0] === 32'h100)
        n_a++;
      else if (bw_grant[0] === 32'h200)
        n_b++;
    end
  endtask : gather

  initial begin
    {cfg_req, cfg_write, cfg_space, cfg_addr, cfg_wdata} = '0;
    bw_req = '0;
    rst = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({26'h0, stride_width}, {26'h0, PS_STRIDE_WIDTH_FIELD}, "stride width");
    acc(1'b1, 2'h1, PS_OFF_SEL, selw(2'h0, 16'h3, 1'b1));
    acc(1'b0, 2'h1, PS_OFF_CFG, 32'h0);
    chk(rd, 32'h0, "reset setting");
    for (k = 0; k < 16; k++) begin
      acc(1'b1, 2'(k / 4), PS_OFF_SEL, selw(2'(k / 2 % 2), k[0] ? 16'h7 : 16'h0, 1'b1));
      acc(1'b1, 2'(k / 4), PS_OFF_CFG, pat(k, 1'b1));
      chk(rd, 32'h0, "write data return");
    end
    for (k = 0; k < 16; k++) begin
      acc(1'b1, 2'(k / 4), PS_OFF_SEL, selw(2'(k / 2 % 2), k[0] ? 16'h7 : 16'h0, 1'b1));
      acc(1'b0, 2'(k / 4), PS_OFF_SEL, 32'h0);
      chk(rd, selw(2'(k / 2 % 2), k[0] ? 16'h7 : 16'h0, 1'b1), "selection readback");
      acc(1'b0, 2'(k / 4), PS_OFF_CFG, 32'h0);
      chk(rd, pat(k, 1'b0), "setting readback");
    end
    acc(1'b1, 2'h1, PS_OFF_SEL, selw(2'h0, 16'h0, 1'b0));
    acc(1'b1, 2'h1, PS_OFF_CFG, 32'h8000_0123);
    acc(1'b0, 2'h1, PS_OFF_CFG, 32'h0);
    chk(rd, 32'h0, "request id access refused");
    acc(1'b1, 2'h1, PS_OFF_SEL, selw(2'h0, 16'h0, 1'b1));
    acc(1'b0, 2'h1, PS_OFF_CFG, 32'h0);
    chk(rd, pat(4, 1'b0), "refused write ignored");
    acc(1'b1, 2'h1, PS_OFF_SEL, selw(2'h0, 16'h8, 1'b1));
    acc(1'b0, 2'h1, PS_OFF_CFG, 32'h0);
    chk(rd, 32'h0, "partition out of range");
    acc(1'b1, 2'h1, PS_OFF_SEL, selw(2'h2, 16'h0, 1'b1));
    acc(1'b0, 2'h1, PS_OFF_CFG, 32'h0);
    chk(rd, 32'h0, "selector out of range");
    acc(1'b1, 2'h1, 12'h504, 32'hffff_ffff);
    acc(1'b0, 2'h1, 12'h504, 32'h0);
    chk(rd, 32'h0, "unmapped offset");
    // Two regulated partitions, costs 1 and 3, one unregulated
    acc(1'b1, 2'h1, PS_OFF_SEL, selw(2'h0, 16'h0, 1'b1));
    acc(1'b1, 2'h1, PS_OFF_CFG, 32'h8000_0000);
    acc(1'b1, 2'h1, PS_OFF_SEL, selw(2'h0, 16'h1, 1'b1));
    acc(1'b1, 2'h1, PS_OFF_CFG, 32'h8000_0002);
    wr_rd(2'h1, 32'hffff_f002);
    chk(rd, 32'h8000_0002, "back-to-back readback");
    @(posedge mclk);
    bw_req[0] <= 32'h0000_0700;
    bw_req[1] <= 32'h0000_0400;
    repeat (3) @(posedge mclk);
    #1;
    chk(bw_grant[0], 32'h400, "unregulated served first");
    chk({30'h0, bw_grant_valid}, 32'h3, "grant valid");
    chk(bw_grant[1], 32'h400, "second instance unregulated");
    @(posedge mclk);
    bw_req[0] <= 32'h0000_0300;
    bw_req[1] <= 32'h0;
    repeat (2) @(posedge mclk);
    gather();
    chk(n_a + n_b, 32'd16, "one grant per cycle");
    chk({31'h0, n_b >= 3 && n_b <= 5}, 32'h1, "cheaper partition favoured");
    // Swap costs: the other partition now wins most cycles
    acc(1'b1, 2'h1, PS_OFF_CFG, 32'h8000_0000);
    acc(1'b1, 2'h1, PS_OFF_SEL, selw(2'h0, 16'h0, 1'b1));
    acc(1'b1, 2'h1, PS_OFF_CFG, 32'h8000_0002);
    repeat (4) @(posedge mclk);
    gather();
    chk({31'h0, n_a >= 3 && n_a <= 5}, 32'h1, "relative cost swapped");
    bw_req <= '0;
    tally_and_finish();
  end
endmodule : ps_stride_cfg_test
